// File: hdl/abc_pkg.sv
// Package of constants and carrier types for the converter host controller
`default_nettype none
package abc_pkg;
    // Clock rate in kHz, times in ns
    localparam int CLK_KHZ = 40000;
    localparam int BLANK_MIN_NS = 2000;
    localparam int DONE_RISE_NS = 1500;
    localparam int DATA_VALID_NS = 500;
    localparam int CONV_MAX_NS = 40000;
    // Cycle counts: least times round up, longest round down
    localparam int BLANK_MIN_CYC = (BLANK_MIN_NS * CLK_KHZ + 999999) / 1000000;
    localparam int DATA_VALID_CYC =
        (DATA_VALID_NS * CLK_KHZ + 999999) / 1000000;
    localparam int CONV_MAX_CYC = (CONV_MAX_NS * CLK_KHZ) / 1000000;
    localparam int TIMEOUT_CYC = CONV_MAX_CYC + 2 * BLANK_MIN_CYC;
    // Converter count and status groups
    localparam int NUM_CONV = 10;
    localparam int NUM_GROUPS = 2;
    localparam int GROUP_SPLIT = 5;
    localparam int DATA_W = 8;
    localparam int CNT_W = 12;
    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam logic [NUM_CONV-1:0] CTRL_RESET = 10'h3ff;
    // Request from user side
    typedef struct packed {
        logic start;
        logic [3:0] sel;
    } abc_req_t;
    // Answer to user side
    typedef struct packed {
        logic done;
        logic timeout;
        logic [3:0] sel;
        logic [DATA_W-1:0] data;
    } abc_rsp_t;
endpackage
`default_nettype wire

// File: hdl/abc_sync.sv
// Three-flop synchroniser with agreement on the last two stages
`default_nettype none
module abc_sync
    import abc_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1, s2, s3;
    logic [W-1:0] next_dout;

    // Accept a bit only when the last two stages agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            next_dout[i] = (s2[i] == s3[i]) ? s3[i] : dout[i];
        end
    end

    // Shift stages
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            dout <= '0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            dout <= next_dout;
        end
    end
endmodule
`default_nettype wire

// File: hdl/abc_host.sv
// Host controller multiplexing ten blank-and-convert converters
//
// How it works
// - Sample-hold gate keeps hold until conversion_done_n falls.
// - Start pulse held until conversion_done_n rises, then line drops.
// - Result sampled from the shared bus only while read is enabled.
// - Completion is polled from the buffered conversion_done_n status.
// - At most one converter has its control line low at once.
// - Next start raises the old line at once; the new line drops only after the blank and the status rise.
// - Status read from two wire-ORed groups, one input each.
// - Every high blank pulse lasts at least 2 us.
`default_nettype none
module abc_host
    import abc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // User request and answer
    input wire abc_req_t req,
    output abc_rsp_t rsp,
    output logic busy,
    // Converter control lines, high blanks
    output logic [NUM_CONV-1:0] blank_convert,
    // Sample-hold control, high holds
    output logic sha_hold,
    // Grouped wire-ORed status pins
    input wire logic [NUM_GROUPS-1:0] conversion_done_n,
    // Shared converter data bus
    input wire logic [DATA_W-1:0] conv_data
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_BLANK, ST_WAIT_RISE, ST_CONVERT, ST_SETTLE
    } abc_state_t;

    // Status group of a given converter
    function automatic logic grp_of(input logic [3:0] s);
        return (s >= 4'(GROUP_SPLIT));
    endfunction

    logic [NUM_GROUPS-1:0] done_sync;
    logic [DATA_W-1:0] data_sync;
    abc_state_t state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic [3:0] cur, next_cur;
    logic [NUM_CONV-1:0] next_blank_convert;
    logic next_sha_hold, next_busy;
    abc_rsp_t next_rsp;
    logic grp_done_n;
    // One-cycle strobes from the sequencer to the output groups
    logic take, drop_line, conv_end, capture, timed_out;

    // Status and data come from another domain
    abc_sync #(.W(NUM_GROUPS)) u_sync_done (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .din(conversion_done_n),
        .dout(done_sync)
    );
    abc_sync #(.W(DATA_W)) u_sync_data (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .din(conv_data),
        .dout(data_sync)
    );

    // Poll status of the selected converter's group
    assign grp_done_n = done_sync[grp_of(cur)];

    // Sequencer: phase, phase counter and selected converter
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_cur = cur;
        // Strobes default low
        take = 1'b0;
        drop_line = 1'b0;
        conv_end = 1'b0;
        capture = 1'b0;
        timed_out = 1'b0;
        case (state)
            ST_IDLE: begin
                // Out-of-range selects are refused silently
                if (req.start && req.sel < 4'(NUM_CONV)) begin
                    take = 1'b1;
                    next_cur = req.sel;
                    next_cnt = '0;
                    next_state = ST_BLANK;
                end
            end
            ST_BLANK: begin
                // Hold blank long enough to clear or restart
                next_cnt = cnt + 1'b1;
                if (cnt >= CNT_W'(BLANK_MIN_CYC - 1)) begin
                    next_cnt = '0;
                    next_state = ST_WAIT_RISE;
                end
            end
            ST_WAIT_RISE: begin
                // Wait for status high, then start conversion
                next_cnt = cnt + 1'b1;
                if (grp_done_n) begin
                    drop_line = 1'b1;
                    next_cnt = '0;
                    next_state = ST_CONVERT;
                end else if (cnt >= CNT_W'(TIMEOUT_CYC)) begin
                    timed_out = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            ST_CONVERT: begin
                // Hold until status falls, then release hold
                next_cnt = cnt + 1'b1;
                if (!grp_done_n) begin
                    conv_end = 1'b1;
                    next_cnt = '0;
                    next_state = ST_SETTLE;
                end else if (cnt >= CNT_W'(TIMEOUT_CYC)) begin
                    timed_out = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            ST_SETTLE: begin
                // Let data go active, then capture it
                next_cnt = cnt + 1'b1;
                if (cnt >= CNT_W'(DATA_VALID_CYC + 3)) begin
                    capture = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            cnt <= '0;
            cur <= SEL_RESET;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            cur <= next_cur;
        end
    end

    // Each line blanks on a take and drops when chosen to convert
    // A line only changes on a take or on its own drop strobe
    for (genvar g = 0; g < NUM_CONV; g++) begin : g_line
        assign next_blank_convert[g] = take ? 1'b1 :
            (drop_line && cur == 4'(g)) ? 1'b0 : blank_convert[g];
    end

    // Sample-hold holds from the line drop until the conversion ends
    always_comb begin
        next_sha_hold = sha_hold;
        // Released at the end, on a timeout and on a new take
        if (take || conv_end || timed_out) begin
            next_sha_hold = 1'b0;
        end else if (drop_line) begin
            next_sha_hold = 1'b1;
        end
    end

    // Control line registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            blank_convert <= CTRL_RESET;
            sha_hold <= 1'b0;
        end else begin
            blank_convert <= next_blank_convert;
            sha_hold <= next_sha_hold;
        end
    end

    // Answer: busy level, held result and one-cycle pulses
    always_comb begin
        next_busy = busy;
        next_rsp = rsp;
        next_rsp.done = 1'b0;
        next_rsp.timeout = 1'b0;
        if (take) begin
            next_busy = 1'b1;
        end else if (capture) begin
            next_rsp.data = data_sync;
            next_rsp.sel = cur;
            next_rsp.done = 1'b1;
            next_busy = 1'b0;
        end else if (timed_out) begin
            next_rsp.timeout = 1'b1;
            next_busy = 1'b0;
        end
    end

    // Answer registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy <= 1'b0;
            rsp <= '0;
        end else begin
            busy <= next_busy;
            rsp <= next_rsp;
        end
    end
endmodule
`default_nettype wire

// File: test/abc_conv_model.sv
// Behavioural model of ten converters on one shared bus
`default_nettype none
module abc_conv_model
    import abc_pkg::*;
#(
    parameter int CONV_CYC = 1000
) (
    // Control lines, next result, status and data
    input wire logic clk_sys,
    input wire logic [NUM_CONV-1:0] blank_convert,
    input wire logic [DATA_W-1:0] value,
    output logic [NUM_GROUPS-1:0] conversion_done_n,
    output logic [DATA_W-1:0] conv_data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [NUM_CONV-1:0] rdy_n = '1, last = '1;
    localparam int STEP = CONV_CYC / DATA_W;
    logic [DATA_W-1:0] res [NUM_CONV], junk = 8'h00;
    logic [DATA_W-1:0] sar [NUM_CONV];
    int cnt [NUM_CONV];
    // Cycles since each control edge set status
    always @(posedge clk_sys) begin
        junk <= junk + 8'h5b;
        last <= blank_convert;
        for (int i = 0; i < NUM_CONV; i++) begin
            int b;
            logic moved;
            b = DATA_W - 1 - cnt[i] / STEP;
            moved = blank_convert[i] !== last[i];
            cnt[i] <= moved ? 0 : cnt[i] + 1;
            // Successive approximation, most significant bit first
            if (moved) sar[i] <= '0;
            else if (!blank_convert[i] && cnt[i] < CONV_CYC &&
                     cnt[i] % STEP == STEP - 1)
                sar[i][b] <= value[b];
            if (!blank_convert[i] && cnt[i] == CONV_CYC) begin
                rdy_n[i] <= 1'b0;
                res[i] <= sar[i];
            end
            if (blank_convert[i] && cnt[i] == 60) rdy_n[i] <= 1'b1;
        end
    end
    // Ready converter with its line low drives, else noise
    always_comb begin
        conv_data = junk;
        for (int i = 0; i < NUM_CONV; i++)
            if (!blank_convert[i] && !rdy_n[i]) conv_data = res[i];
    end
    assign conversion_done_n = {&rdy_n[9:5], &rdy_n[4:0]};
endmodule
`default_nettype wire

// File: test/abc_host_chk.sv
// Checker of the host controller ports
`default_nettype none
module abc_host_chk
    import abc_pkg::*;
(
    // Watched ports
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire abc_req_t req,
    input wire abc_rsp_t rsp,
    input wire logic busy,
    input wire logic [NUM_CONV-1:0] blank_convert,
    input wire logic sha_hold,
    input wire logic [NUM_GROUPS-1:0] conversion_done_n,
    input wire logic [DATA_W-1:0] conv_data
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int BLK = BLANK_MIN_CYC - 1;
    logic all_blank;
    assign all_blank = blank_convert == CTRL_RESET;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence s_wait; (busy && !rsp.done) [*8]; endsequence
    property p_low; $countones(~blank_convert) <= 1; endproperty
    a_low: assert property (p_low) else $error("two lines low");
    property p_take;
        req.start && !busy && req.sel < NUM_CONV |=> busy && all_blank;
    endproperty
    a_take: assert property (p_take) else $error("start lost");
    property p_blank; $rose(busy) |-> all_blank throughout (##BLK 1); endproperty
    a_blank: assert property (p_blank) else $error("short blank");
    property p_hold; $rose(sha_hold) |-> $past(all_blank) && !all_blank;
    endproperty
    a_hold: assert property (p_hold) else $error("hold moment");
    property p_keep; sha_hold && &conversion_done_n |=> sha_hold; endproperty
    a_keep: assert property (p_keep) else $error("hold lost");
    property p_free; sha_hold && !(&conversion_done_n) |-> ##[1:8] !sha_hold;
    endproperty
    a_free: assert property (p_free) else $error("hold stuck");
    property p_res; $fell(sha_hold) |-> s_wait ##[1:40] rsp.done; endproperty
    a_res: assert property (p_res) else $error("result time");
    property p_done;
        rsp.done |-> (rsp.data == conv_data && !busy && !all_blank) ##1 !rsp.done;
    endproperty
    a_done: assert property (p_done) else $error("bad result");
endmodule
bind abc_host abc_host_chk abc_host_chk_i (.clk_sys, .arst_n, .req, .rsp,
    .busy, .blank_convert, .sha_hold, .conversion_done_n, .conv_data);
`default_nettype wire

// File: test/abc_host_tb.sv
// Bench for the host controller with one model of ten converters
`default_nettype none
module abc_host_tb
    import abc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0, arst_n = 1'b0, busy, sha_hold;
    abc_req_t req = '0;
    abc_rsp_t rsp;
    logic [NUM_CONV-1:0] blank_convert;
    logic [NUM_GROUPS-1:0] conversion_done_n;
    logic [DATA_W-1:0] conv_data, value = 8'h00;
    logic [11:0] exp_q [$];
    int error_cnt = 0, num_checks = 0;
    always #12.5 clk_sys = ~clk_sys;
    abc_host abc_host_i (.clk_sys, .arst_n, .req, .rsp, .busy, .blank_convert,
        .sha_hold, .conversion_done_n, .conv_data);
    abc_conv_model abc_conv_model_i (.clk_sys, .blank_convert, .value,
        .conversion_done_n, .conv_data);
    task automatic check(input logic [11:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // One conversion, with a refused start while busy
    task automatic convert(input logic [3:0] sel);
        value = 8'($urandom);
        exp_q.push_back({sel, value});
        req = '{start: 1'b1, sel: sel};
        @(posedge clk_sys) #2;
        req.sel = (sel == 4'h9) ? 4'h0 : sel + 4'h1;
        repeat (3) @(posedge clk_sys) #2;
        req.start = 1'b0;
        for (int n = 0; n < 3000 && rsp.done !== 1'b1; n++)
            @(posedge clk_sys) #2;
        check({11'h0, rsp.done}, 12'h001);
        check({9'h0, rsp.timeout, busy, sha_hold}, 12'h000);
        check({rsp.sel, rsp.data}, exp_q.pop_front());
        check({2'h0, blank_convert}, {2'h0, ~(10'h001 << sel)});
    endtask
    initial begin
        void'($urandom(10));
        repeat (10) @(posedge clk_sys) #2;
        check({1'b0, sha_hold, blank_convert}, {2'h0, CTRL_RESET});
        arst_n = 1'b1;
        $display("Test reset done");
        for (int k = 0; k < 14; k++)
            convert(k < 10 ? 4'(k) : 4'($urandom_range(9)));
        $display("Test conversions done");
        // Out-of-range select must be refused
        req = '{start: 1'b1, sel: 4'(10 + $urandom_range(5))};
        repeat (4) @(posedge clk_sys) #2;
        check({11'h0, busy}, 12'h000);
        req.start = 1'b0;
        $display("Test refused select done");
        close_out();
    end
    // Watchdog on a hung run
    initial begin
        #750000;
        error_cnt++;
        close_out();
    end
endmodule
`default_nettype wire
